// >>> inc/cor_consts.vh
`ifndef COR_CONSTS_VH
`define COR_CONSTS_VH
// counter and storage widths
`define COR_WIDTH 8
`define COR_CNT_RESET 8'h00
`define COR_CNT_ONES 8'hff
`define COR_CNT_STEP 8'h01
`define COR_REG_RESET 8'h00
`endif

// >>> verilog/cor_sync2.v
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for one level
module cor_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // level in and out
  input wire din,
  output reg dout
);

  reg meta_ff;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/cor_counter_out_reg.v
// Notes on behaviour
// - an 8-bit counter feeds a separate 8-bit register driving the outputs
// - output enable high floats the outputs; low drives them from the register
// - counter and register each step on the rising edge of their own clock
// - each capture clock rising edge copies the counter into the register
// - falling capture clock edges leave the register unchanged
// - clear low holds the counter at zero; the register is untouched
// - with clear high and enable low, each count clock rise adds one
// - carry output is low exactly when all counter bits are one
// - toggling the count enable never advances the counter by itself
// - with both clocks tied, the register lags the counter by one count
`timescale 1ns/100ps
`default_nettype none
`include "cor_consts.vh"
module cor_counter_out_reg (
  // system clock and reset
  input wire clk,
  input wire rstn,
  // pin inputs, asynchronous to clk
  input wire count_clock,
  input wire capture_clock,
  input wire count_enable_n,
  input wire counter_clear_n,
  input wire output_enable_n,
  // three-state parallel outputs
  output wire [`COR_WIDTH-1:0] parallel_out,
  output wire [`COR_WIDTH-1:0] parallel_out_oe,
  // carry output
  output reg carry_out_n
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  wire cclk_s;
  wire rclk_s;
  wire cen_n_s;
  wire clr_n_s;
  wire oe_n_s;

  // counter clock pin
  cor_sync2 #(
    .RESET_VAL(1'b0)
  ) u_sync_cclk (
    .clk(clk),
    .rstn(rstn),
    .din(count_clock),
    .dout(cclk_s)
  );

  // capture clock pin
  cor_sync2 #(
    .RESET_VAL(1'b0)
  ) u_sync_rclk (
    .clk(clk),
    .rstn(rstn),
    .din(capture_clock),
    .dout(rclk_s)
  );

  // count enable pin, idles disabled
  cor_sync2 #(
    .RESET_VAL(1'b1)
  ) u_sync_cen (
    .clk(clk),
    .rstn(rstn),
    .din(count_enable_n),
    .dout(cen_n_s)
  );

  // counter clear pin, idles inactive
  cor_sync2 #(
    .RESET_VAL(1'b1)
  ) u_sync_clr (
    .clk(clk),
    .rstn(rstn),
    .din(counter_clear_n),
    .dout(clr_n_s)
  );

  // output enable pin, idles floating
  cor_sync2 #(
    .RESET_VAL(1'b1)
  ) u_sync_oe (
    .clk(clk),
    .rstn(rstn),
    .din(output_enable_n),
    .dout(oe_n_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // edge detection on the two pin clocks

  reg cclk_d_ff;
  reg rclk_d_ff;
  wire cclk_rise;
  wire rclk_rise;

  function cor_rise;
    input now_lvl;
    input prev_lvl;
    begin
      cor_rise = now_lvl & ~prev_lvl;
    end
  endfunction

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cclk_d_ff <= 1'b0;
    end else begin
      cclk_d_ff <= cclk_s;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rclk_d_ff <= 1'b0;
    end else begin
      rclk_d_ff <= rclk_s;
    end
  end

  // only rising edges count; falling edges and enable changes do nothing
  assign cclk_rise = cor_rise(cclk_s, cclk_d_ff);
  assign rclk_rise = cor_rise(rclk_s, rclk_d_ff);

  ////////////////////////////////////////////////////////////////////////
  // counter arithmetic and decode

  function [`COR_WIDTH-1:0] cor_inc;
    input [`COR_WIDTH-1:0] value;
    reg [`COR_WIDTH:0] sum;
    begin
      sum = {1'b0, value} + {1'b0, `COR_CNT_STEP};
      cor_inc = sum[`COR_WIDTH-1:0];
    end
  endfunction

  function cor_all_ones;
    input [`COR_WIDTH-1:0] value;
    begin
      cor_all_ones = (value == `COR_CNT_ONES);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // counter and storage register

  reg [`COR_WIDTH-1:0] count_ff;
  reg [`COR_WIDTH-1:0] nxt_count;
  reg [`COR_WIDTH-1:0] store_ff;
  reg [`COR_WIDTH-1:0] nxt_store;
  reg nxt_carry_n;

  always @* begin
    nxt_count = count_ff;
    if (!clr_n_s) begin
      nxt_count = `COR_CNT_RESET;
    end else if (cclk_rise && !cen_n_s) begin
      nxt_count = cor_inc(count_ff);
    end
  end

  always @* begin
    nxt_store = store_ff;
    if (rclk_rise) begin
      // old count is taken, so tied clocks show a lag of one
      nxt_store = count_ff;
    end
  end

  always @* begin
    // decoded from the next count so it stays in step with count_ff
    nxt_carry_n = ~cor_all_ones(nxt_count);
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_ff <= `COR_CNT_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      store_ff <= `COR_REG_RESET;
    end else begin
      store_ff <= nxt_store;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      carry_out_n <= 1'b1;
    end else begin
      carry_out_n <= nxt_carry_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // three-state output drive

  reg [`COR_WIDTH-1:0] oe_vec;

  always @* begin
    oe_vec = {`COR_WIDTH{~oe_n_s}};
  end

  // the pad ring floats the pins while oe is low
  assign parallel_out = store_ff;
  assign parallel_out_oe = oe_vec;

endmodule
`default_nettype wire

// >>> verification/cor_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module cor_chk(input wire logic clk,rstn,count_clock,capture_clock,count_enable_n,
  counter_clear_n,output_enable_n,carry_out_n,input wire logic [7:0] parallel_out,parallel_out_oe);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence idle_s; (count_enable_n&&counter_clear_n)[*6]; endsequence
  a_store_src: assert property(!$stable(parallel_out)|->$past(capture_clock,3))
    else $error("store");
  a_store_hold: assert property(!capture_clock[*6]|->$stable(parallel_out))
    else $error("hold");
  a_oe_level: assert property($stable(output_enable_n)[*5]|->
    parallel_out_oe=={8{!output_enable_n}}) else $error("oe");
  a_oe_whole: assert property(parallel_out_oe==8'h00||parallel_out_oe==8'hff)
    else $error("oe bits");
  a_carry_src: assert property(!$stable(carry_out_n)|->$past(count_clock,3)||
    !$past(counter_clear_n,3)) else $error("carry");
  a_clear_zero: assert property(!counter_clear_n[*5]|->carry_out_n) else $error("clear");
  a_idle_hold: assert property(idle_s|->$stable(carry_out_n)) else $error("idle");
  a_wrap_ones: assert property(!carry_out_n&&$rose(count_clock)&&!count_enable_n&&
    counter_clear_n|->##[3:4] carry_out_n) else $error("wrap");
endmodule
bind cor_counter_out_reg cor_chk u_chk(.*);
`default_nettype wire

// >>> verification/cor_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module cor_far_side(input wire logic clk,input wire logic [1:0] fire,
  output logic count_clock,capture_clock);
  initial {capture_clock,count_clock}=2'b00;
  always @(posedge clk) {capture_clock,count_clock}<=fire;
endmodule
`default_nettype wire

// >>> verification/test_counter_with_output_register.sv
`timescale 1ns/100ps
`default_nettype none
module test_counter_with_output_register;
  logic clk=0,rstn=0,count_enable_n=1,counter_clear_n=1,output_enable_n=1;
  logic [1:0] fire=0;
  wire logic count_clock,capture_clock,carry_out_n;
  wire logic [7:0] parallel_out,parallel_out_oe;
  wire logic [7:0] out2,out3;
  int errors=0,samples_checked=0,seed=32'h7712,n=0,s=0,r,i,n2=0,s2=0,n3=0,s3=0;
  always #5 clk=~clk;
  cor_far_side fs(.*);
  cor_counter_out_reg uut(.*);
  // second stage enabled by the first stage's carry
  cor_counter_out_reg u_casc(.clk,.rstn,.count_clock,.capture_clock,.count_enable_n(carry_out_n),
    .counter_clear_n,.output_enable_n,.parallel_out(out2),.parallel_out_oe(),.carry_out_n());
  // third stage clocked by the first stage's carry
  cor_counter_out_reg u_chain(.clk,.rstn,.count_clock(carry_out_n),.capture_clock,
    .count_enable_n,.counter_clear_n,.output_enable_n,.parallel_out(out3),.parallel_out_oe(),
    .carry_out_n());
  task chk(input logic [7:0] v,e);
    samples_checked++;
    if(v!==e) begin errors++; $display("ERROR %0t %h %h",$time,v,e); end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d",errors,samples_checked);
    if(errors==0&&samples_checked>0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat(4) @(posedge clk);
    rstn<=1;
    // let the carry-fed stage see its idle-high clock before counting is enabled
    repeat(4) @(posedge clk);
    for(i=0;i<800;i++) begin
      r=$random(seed);
      count_enable_n<=&r[2:0];
      counter_clear_n<=i<400||r[7:4];
      output_enable_n<=&r[10:8];
      repeat(5) @(posedge clk);
      fire<={r[12],r[11]|r[13]};
      repeat(4) @(posedge clk);
      fire<=0;
      if(!counter_clear_n) begin n=0; n2=0; n3=0; end
      if(r[12]) begin s=n; s2=n2; s3=n3; end
      if(fire[0]&&counter_clear_n&&n==255) n2=(n2+1)&255;
      if(fire[0]&&!count_enable_n&&counter_clear_n) begin
        if(n==255) n3=(n3+1)&255;
        n=(n+1)&255;
      end
      repeat(9) @(posedge clk);
      #1 chk(parallel_out,s[7:0]);
      chk({7'h0,carry_out_n},{7'h0,n!=255});
      chk(parallel_out_oe,{8{~output_enable_n}});
      chk(out2,s2[7:0]);
      chk(out3,s3[7:0]);
      @(posedge clk);
    end
    end_of_test;
  end
endmodule
`default_nettype wire
